/* File: include/spr_map.vh */
`ifndef SPR_MAP_VH
`define SPR_MAP_VH
// Byte addresses on APB: register index times four.
`define SPR_IDX_NODE      4'h0
`define SPR_IDX_GAPCTL    4'h1
`define SPR_IDX_EXTPORT   4'h2
`define SPR_IDX_SPEED     4'h3
`define SPR_IDX_LINKPWR   4'h4
`define SPR_IDX_EVENT     4'h5
`define SPR_IDX_RSVD6     4'h6
`define SPR_IDX_PAGESEL   4'h7
`define SPR_IDX_IRQ_STAT  4'h8
`define SPR_IDX_IRQ_MASK  4'h9
`define SPR_IDX_EVT_CTRL  4'hA
`define SPR_BANK_LIMIT    4'hF
`define SPR_PAGE_W        3
`define SPR_PAGE_RSVD_LO  3'h2
`define SPR_PAGE_RSVD_HI  3'h6
`define SPR_GAP_RESET     6'h3F
`define SPR_EXTENDED      3'h7
`define SPR_NUM_PORTS     4'h6
`define SPR_SPEED_CODE    3'h2
`define SPR_DELAY_CODE    4'h0
`define SPR_LONG_RESET_US 166
`define SPR_CLK_MHZ       50
`define SPR_IRQ_W         4
`define SPR_IRQ_SELFID    0
`define SPR_IRQ_ROOT      1
`define SPR_IRQ_POWER     2
`define SPR_IRQ_BRESET    3
`endif

/* File: design/spr_base_regs.v */
// Behaviour
// - Sixteen registers: eight base, eight paged window.
// - Page select in base register 7 picks page.
// - Base registers never change with the page.
// - Reserved registers and fields read zero.
// - Pages two to six read all zero.
// - Node identifier read-only, invalid until self-ID done.
// - Root flag cleared by bus reset, set when root.
// - Cable power bit mirrors the power input.
// - Root holdoff cleared by hardware reset or a write of 0, not by bus reset.
// - Long reset request starts 166 us bus reset.
// - Long reset waits for traffic in progress.
// - Long reset request cleared by either reset.
// - Gap value drives the arbitration timing outputs.
// - Gap updated by write or configuration packet.
// - Gap 3Fh on reset or two bare bus resets.
// - Extended field reads constant 111b.
// - Port count field reads constant six.
// - Speed code 010b, delay code 0000b.
`timescale 1ns/10ps
`default_nettype none
`include "spr_map.vh"
module spr_base_regs #(
  parameter LONG_RESET_CYCLES = `SPR_LONG_RESET_US * `SPR_CLK_MHZ
) (
  input  wire        clk_in,
  input  wire        reset_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [5:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  input  wire        bus_reset_in,
  input  wire        selfid_done_in,
  input  wire [5:0]  selfid_node_in,
  input  wire        became_root_in,
  input  wire        cable_power_in,
  input  wire        link_busy_in,
  input  wire        cfg_gap_valid_in,
  input  wire [5:0]  cfg_gap_in,
  input  wire [7:0]  page_data_in,
  output reg  [2:0]  page_sel_out,
  output reg  [3:0]  port_sel_out,
  output reg  [5:0]  gap_count_out,
  output reg         root_holdoff_out,
  output reg         long_reset_out,
  output reg         node_id_valid_out,
  output reg         irq_out
);
  localparam [31:0] LR_CYC = LONG_RESET_CYCLES;

  reg [5:0]  node_id_q;
  reg        node_valid_q;
  reg        root_q;
  reg        power_q;
  reg        holdoff_q;
  reg        lr_req_q;
  reg        lr_active_q;
  reg [31:0] lr_cnt_q;
  reg [5:0]  gap_q;
  reg        gap_touched_q;
  reg        bare_reset_q;
  reg [2:0]  page_q;
  reg [3:0]  port_q;
  reg [`SPR_IRQ_W-1:0] stat_q;
  reg [`SPR_IRQ_W-1:0] mask_q;
  reg [7:0]  rd_byte;
  reg        rd_err;
  wire       access  = psel_in & penable_in;
  wire       wr_acc  = access & pwrite_in;
  wire       rd_acc  = access & ~pwrite_in;
  wire [3:0] idx     = paddr_in[5:2];
  wire       misalign = (paddr_in[1:0] != 2'h0);
  wire       wr_gap  = wr_acc & ~misalign & (idx == `SPR_IDX_GAPCTL);
  wire       page_rsvd = (page_q >= `SPR_PAGE_RSVD_LO) && (page_q <= `SPR_PAGE_RSVD_HI);
  wire [`SPR_IRQ_W-1:0] events;

  assign events[`SPR_IRQ_SELFID] = selfid_done_in;
  assign events[`SPR_IRQ_ROOT]   = became_root_in;
  assign events[`SPR_IRQ_POWER]  = power_q & ~cable_power_in;
  assign events[`SPR_IRQ_BRESET] = bus_reset_in;

  // Read mux; base registers ignore the page, the window follows it.
  always @* begin
    rd_byte = 8'h00;
    rd_err  = 1'b0;
    case (idx)
      `SPR_IDX_NODE:    rd_byte = {node_id_q, root_q, power_q};
      `SPR_IDX_GAPCTL:  rd_byte = {holdoff_q, lr_req_q, gap_q};
      `SPR_IDX_EXTPORT: rd_byte = {`SPR_EXTENDED, 1'b0, `SPR_NUM_PORTS};
      `SPR_IDX_SPEED:   rd_byte = {`SPR_SPEED_CODE, 1'b0, `SPR_DELAY_CODE};
      `SPR_IDX_PAGESEL: rd_byte = {page_q, 1'b0, port_q};
      default: begin
        if (idx > `SPR_IDX_PAGESEL) begin
          rd_byte = page_rsvd ? 8'h00 : page_data_in;
        end else begin
          rd_byte = 8'h00;
        end
      end
    endcase
    if (misalign) begin
      rd_err = 1'b1;
    end
  end

  // Status and mask live at paged-window indices on page 7 only, so they
  // shadow no real paged content on pages 0 and 1.
  wire page_ctl = (page_q == 3'h7);

  // APB slave: zero wait state, answers in the access cycle.
  always @(posedge clk_in) begin
    if (reset_in) begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & (paddr_in[1:0] != 2'h0);
      if (psel_in & ~penable_in) begin
        if (page_ctl && idx == `SPR_IDX_IRQ_STAT) begin
          prdata_out <= {{(32-`SPR_IRQ_W){1'b0}}, stat_q};
        end else if (page_ctl && idx == `SPR_IDX_IRQ_MASK) begin
          prdata_out <= {{(32-`SPR_IRQ_W){1'b0}}, mask_q};
        end else begin
          prdata_out <= {24'h00_0000, rd_byte};
        end
      end
    end
  end

  // Identity, root and power state.
  always @(posedge clk_in) begin
    if (reset_in) begin
      node_id_q    <= 6'h00;
      node_valid_q <= 1'b0;
      root_q       <= 1'b0;
      power_q      <= 1'b0;
    end else begin
      power_q <= cable_power_in;
      if (bus_reset_in) begin
        node_valid_q <= 1'b0;
        root_q       <= 1'b0;
      end else begin
        if (selfid_done_in) begin
          node_id_q    <= selfid_node_in;
          node_valid_q <= 1'b1;
        end
        if (became_root_in) begin
          root_q <= 1'b1;
        end
      end
    end
  end

  // Control writes. Read-only bits have no write path at all.
  always @(posedge clk_in) begin
    if (reset_in) begin
      holdoff_q <= 1'b0;
      page_q    <= 3'h0;
      port_q    <= 4'h0;
      mask_q    <= {`SPR_IRQ_W{1'b0}};
    end else if (wr_acc & ~misalign) begin
      if (idx == `SPR_IDX_GAPCTL) begin
        holdoff_q <= pwdata_in[7];
      end
      if (idx == `SPR_IDX_PAGESEL) begin
        page_q <= pwdata_in[7:5];
        port_q <= pwdata_in[3:0];
      end
      if (page_ctl && idx == `SPR_IDX_IRQ_MASK) begin
        mask_q <= pwdata_in[`SPR_IRQ_W-1:0];
      end
    end
  end

  // Long reset: request waits for idle link, then runs the full length.
  always @(posedge clk_in) begin
    if (reset_in) begin
      lr_req_q    <= 1'b0;
      lr_active_q <= 1'b0;
      lr_cnt_q    <= 32'h0000_0000;
    end else begin
      if (lr_active_q) begin
        if (lr_cnt_q == LR_CYC - 32'h0000_0001) begin
          lr_active_q <= 1'b0;
        end
        lr_cnt_q <= lr_cnt_q + 32'h0000_0001;
      end else if (lr_req_q & ~link_busy_in) begin
        lr_active_q <= 1'b1;
        lr_cnt_q    <= 32'h0000_0000;
      end
      // The long reset is itself a bus reset, so it consumes the request;
      // otherwise a single request would repeat the reset forever.
      if (bus_reset_in | (lr_req_q & ~lr_active_q & ~link_busy_in)) begin
        lr_req_q <= 1'b0;
      end else if (wr_gap) begin
        lr_req_q <= pwdata_in[6];
      end
    end
  end

  // Gap value: write or config packet; two bare bus resets restore 3Fh.
  always @(posedge clk_in) begin
    if (reset_in) begin
      gap_q         <= `SPR_GAP_RESET;
      gap_touched_q <= 1'b0;
      bare_reset_q  <= 1'b0;
    end else if (wr_gap) begin
      gap_q         <= pwdata_in[5:0];
      gap_touched_q <= 1'b1;
    end else if (cfg_gap_valid_in) begin
      gap_q         <= cfg_gap_in;
      gap_touched_q <= 1'b1;
    end else if (bus_reset_in) begin
      gap_touched_q <= 1'b0;
      bare_reset_q  <= 1'b1;
      if (~gap_touched_q & bare_reset_q) begin
        gap_q <= `SPR_GAP_RESET;
      end
    end
  end

  // Sticky status; set wins over the clear-on-read.
  wire rd_stat = rd_acc & page_ctl & (idx == `SPR_IDX_IRQ_STAT);
  always @(posedge clk_in) begin
    if (reset_in) begin
      stat_q <= {`SPR_IRQ_W{1'b0}};
    end else begin
      stat_q <= (rd_stat ? {`SPR_IRQ_W{1'b0}} : stat_q) | events;
    end
  end

  // Registered outputs.
  always @(posedge clk_in) begin
    if (reset_in) begin
      page_sel_out      <= 3'h0;
      port_sel_out      <= 4'h0;
      gap_count_out     <= `SPR_GAP_RESET;
      root_holdoff_out  <= 1'b0;
      long_reset_out    <= 1'b0;
      node_id_valid_out <= 1'b0;
      irq_out           <= 1'b0;
    end else begin
      page_sel_out      <= page_q;
      port_sel_out      <= port_q;
      gap_count_out     <= gap_q;
      root_holdoff_out  <= holdoff_q;
      long_reset_out    <= lr_active_q;
      node_id_valid_out <= node_valid_q;
      irq_out           <= |(stat_q & mask_q);
    end
  end
endmodule // spr_base_regs
`default_nettype wire

/* File: verification/spr_base_regs_props.sv */
`timescale 1ns/10ps
`default_nettype none
// Checks reads in their access cycle, so a late or stale answer fails at once.
module spr_base_regs_props #(
  parameter LONG_RESET_CYCLES = 20
) (
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [5:0]  paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [2:0]  page_sel_out,
  input wire logic        long_reset_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire logic acc = psel_in && penable_in;
  wire logic rd = acc && !pwrite_in;
  logic [15:0] hi_q;
  // Counts the cycles the long reset stays high; cleared when it is low.
  always @(posedge clk_in) hi_q <= (reset_in || !long_reset_out) ? 16'h0 : hi_q + 16'h1;
  no_wait_a: assert property (acc |-> pready_out) else $error("no ready");
  misalign_a: assert property (acc && paddr_in[1:0] != 2'h0 |-> pslverr_out)
    else $error("misaligned access accepted");
  upper_zero_a: assert property (rd |-> prdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  ext_ports_a: assert property (rd && paddr_in == 6'h08 |-> prdata_out == 32'hE6)
    else $error("port count register wrong");
  speed_code_a: assert property (rd && paddr_in == 6'h0C |-> prdata_out == 32'h40)
    else $error("speed register wrong");
  rsvd_regs_a: assert property (rd && paddr_in inside {6'h10, 6'h14, 6'h18} |->
    prdata_out == 32'h0) else $error("reserved register not zero");
  rsvd_page_a: assert property (rd && paddr_in[5] && page_sel_out inside {[3'h2:3'h6]} |->
    prdata_out == 32'h0) else $error("reserved page not zero");
  long_len_a: assert property ($fell(long_reset_out) |-> hi_q == LONG_RESET_CYCLES)
    else $error("long reset length wrong");
  cover property (rd && paddr_in[5]);
  cover property ($fell(long_reset_out));
  cover property (acc && pslverr_out);
endmodule // spr_base_regs_props
bind spr_base_regs spr_base_regs_props #(.LONG_RESET_CYCLES(LONG_RESET_CYCLES)) i_props (
  .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .page_sel_out(page_sel_out), .long_reset_out(long_reset_out));
`default_nettype wire

/* File: verification/spr_page_source.sv */
`timescale 1ns/10ps
`default_nettype none
// Paged content follows page and port, so a stale select shows in the data.
module spr_page_source (
  input  wire logic [2:0] page_sel_in,
  input  wire logic [3:0] port_sel_in,
  output logic      [7:0] page_data_out
);
  assign page_data_out = {~page_sel_in, 1'b1, port_sel_in};
endmodule // spr_page_source
`default_nettype wire

/* File: verification/tb_serial_phy_base_registers.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_serial_phy_base_registers;
  logic        clk_in = 0, reset_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic        cable_power_in = 1, link_busy_in = 0, pslverr_out, pready_out, err;
  logic        root_holdoff_out, long_reset_out, node_id_valid_out, irq_out;
  logic [3:0]  ev = 4'h0, port_sel_out;
  logic [5:0]  paddr_in = 0, selfid_node_in = 0, cfg_gap_in = 0, gap_count_out;
  logic [31:0] pwdata_in = 0, prdata_out, q;
  logic [7:0]  page_data_in;
  logic [2:0]  page_sel_out;
  int          miscompares = 0, tests_run = 0, n, p;
  spr_base_regs #(.LONG_RESET_CYCLES(20)) i_dut (.clk_in(clk_in), .reset_in(reset_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .bus_reset_in(ev[0]), .selfid_done_in(ev[1]),
    .selfid_node_in(selfid_node_in), .became_root_in(ev[2]), .cable_power_in(cable_power_in),
    .link_busy_in(link_busy_in), .cfg_gap_valid_in(ev[3]), .cfg_gap_in(cfg_gap_in),
    .page_data_in(page_data_in), .page_sel_out(page_sel_out), .port_sel_out(port_sel_out),
    .gap_count_out(gap_count_out), .root_holdoff_out(root_holdoff_out),
    .long_reset_out(long_reset_out), .node_id_valid_out(node_id_valid_out), .irq_out(irq_out));
  spr_page_source i_page (.page_sel_in(page_sel_out), .port_sel_in(port_sel_out),
    .page_data_out(page_data_in));
  // Free-running 50 MHz clock.
  initial forever #10 clk_in = ~clk_in;
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One APB transfer; read data and error are taken at the edge that sees pready.
  task apb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1;
    n = 0;
    do begin @(posedge clk_in); n++; end while (pready_out !== 1'b1 && n < 16);
    if (n == 16) begin
      miscompares++;
      stop_test;
    end
    q = prdata_out;
    err = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
  endtask
  task rd(input logic [3:0] i, input logic [31:0] e);
    apb(1'b0, {i, 2'h0}, 32'h0);
    chk(q, e);
  endtask
  // Event pulses last one cycle; registered outputs get time to settle.
  task pulse(input int k);
    @(posedge clk_in);
    ev <= 4'h1 << k;
    @(posedge clk_in);
    ev <= 4'h0;
    repeat (3) @(posedge clk_in);
  endtask
  task t_gap;
    rd(4'h1, 32'h3F);
    apb(1'b1, 6'h04, 32'h95);
    rd(4'h1, 32'h95);
    chk(32'(gap_count_out), 32'h15);
    cfg_gap_in <= 6'h0A;
    pulse(3);
    rd(4'h1, 32'h8A);
    pulse(0);
    rd(4'h1, 32'h8A);
    pulse(0);
    rd(4'h1, 32'hBF);
  endtask
  task t_node;
    pulse(0);
    chk(32'(node_id_valid_out), 32'h0);
    selfid_node_in <= 6'h2A;
    pulse(1);
    chk(32'(node_id_valid_out), 32'h1);
    pulse(2);
    apb(1'b1, 6'h00, 32'h0);
    rd(4'h0, 32'hAB);
    cable_power_in <= 0;
    rd(4'h0, 32'hAA);
    apb(1'b0, 6'h05, 32'h0);
    chk(32'(err), 32'h1);
    pulse(0);
    rd(4'h0, 32'hA8);
    cable_power_in <= 1;
  endtask
  // Walks all eight pages; reads window index 8 or F, the page select and fixed base register 2.
  task t_page;
    for (p = 0; p < 8; p++) begin
      apb(1'b1, 6'h1C, {24'h0, 3'(p), 5'h05});
      rd(4'h7, {24'h0, 3'(p), 5'h05});
      rd(4'h2, 32'hE6);
      apb(1'b0, (p == 7) ? 6'h3C : 6'h20, 32'h0);
      chk(q, (p > 1 && p < 7) ? 32'h0 : {24'h0, ~3'(p), 5'h15});
    end
  endtask
  task t_irq;
    apb(1'b1, 6'h24, 32'hF);
    apb(1'b0, 6'h20, 32'h0);
    pulse(0);
    chk(32'(irq_out), 32'h1);
    rd(4'h8, 32'h08);
    rd(4'h8, 32'h00);
    apb(1'b1, 6'h24, 32'h0);
    pulse(0);
    chk(32'(irq_out), 32'h0);
  endtask
  task t_long;
    link_busy_in <= 1;
    apb(1'b1, 6'h04, 32'h7F);
    rd(4'h1, 32'h7F);
    pulse(0);
    rd(4'h1, 32'h3F);
    apb(1'b1, 6'h04, 32'h7F);
    repeat (10) @(posedge clk_in);
    chk(32'(long_reset_out), 32'h0);
    link_busy_in <= 0;
    n = 0;
    repeat (40) begin @(posedge clk_in); if (long_reset_out === 1'b1) n++; end
    chk(32'(n), 32'd20);
    rd(4'h1, 32'h3F);
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    reset_in <= 0;
    t_gap;
    t_node;
    t_page;
    t_irq;
    t_long;
    stop_test;
  end
  // Guards against a hang anywhere in the sequence.
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    stop_test;
  end
endmodule // tb_serial_phy_base_registers
`default_nettype wire
